// >>> cpu_core_model.sv
`default_nettype none
module cpu_core_model
    import mem_map_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Access request to the decoder
    output acc_req_t req_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial req_o = '0;

    // One access per call, held across its sampling edge
    task automatic issue(input acc_kind_t k, input logic [15:0] a);
        @(posedge clk_i);
        #1 req_o = '{valid: 1'b1, kind: k, addr: a};
        @(posedge clk_i);
        // Idle bus shows a scrambled address so stale values are not reused
        #1 req_o = '{valid: 1'b0, kind: k, addr: ~a};
    endtask : issue
endmodule : cpu_core_model
`default_nettype wire

// >>> cpu_memory_map_decoder.sv
// Overview of operation
// - One 64 KB space for fetch and data
// - Size registers reset to CFH and 0CH
// - Size codes give flash and fast RAM sizes
// - Expansion codes give expansion RAM sizes
// - Banked parts: 48 KB code, 16 KB window
// - Flash starts at 0000H, contiguous to top
// - Program memory holds code and table data
// - 0000H to 003FH is vector storage
// - Vector low byte even, high byte odd
// - Resets use 0000H, interrupts 0004H to 0034H
// - 0040H to 007FH holds table call entries
// - Option bytes at 0080H, mirror with swap
// - Debug identifier at 0085H, mirror with swap
// - Short call targets only 0800H to 0FFFH
// - Security may block boot cluster 0 writes
// - Bank select register picks window bank
`default_nettype none
`include "mem_map_params.svh"

module cpu_memory_map_decoder
    import mem_map_pkg::*;
#(
    parameter int NUM_BANKS = 6,
    parameter bit HAS_DEBUG_ID = 1'b1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Size and bank register writes from the core
    input wire logic mss_wr_i,
    input wire logic xss_wr_i,
    input wire logic bank_wr_i,
    input wire logic [7:0] wdata_i,
    // Static controls from same-clock logic
    input wire logic boot_swap_i,
    input wire logic boot0_protect_i,
    // Access request from the core
    input wire acc_req_t req_i,
    // Decoded access
    output acc_resp_t resp_o,
    // Configuration state
    output logic [7:0] memory_size_select_o,
    output logic [7:0] expansion_ram_size_select_o,
    output logic [2:0] bank_sel_o,
    output logic cfg_error_o
);

    logic [7:0] mss;
    logic [7:0] xss;
    logic [2:0] bank;

    mem_map_size_regs #(
        .BANK_W(3)
    ) u_size_regs (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .mss_wr_i(mss_wr_i),
        .xss_wr_i(xss_wr_i),
        .bank_wr_i(bank_wr_i),
        .wdata_i(wdata_i),
        .mss_o(mss),
        .xss_o(xss),
        .bank_o(bank)
    );

    assign memory_size_select_o = mss;
    assign expansion_ram_size_select_o = xss;
    assign bank_sel_o = bank;

    // Decode runs on the live register values, so a write counts from the next access
    wire rom_cfg_t rom = rom_decode(mss);
    wire exp_cfg_t xr = exp_decode(xss);
    wire logic banked = (NUM_BANKS != 0) && (mss == `MSS_48K);
    wire logic [15:0] a = req_i.addr;

    wire logic in_sfr = a >= `SFR_BASE;
    wire logic in_hs = in_range(a, rom.hs_base, `HS_TOP);
    wire logic in_exp = xr.en && in_range(a, xr.base, `XR_TOP);
    wire logic in_win = banked && in_range(a, `WIN_BASE, `WIN_TOP);
    wire logic bank_ok = 32'(bank) < NUM_BANKS;
    wire logic in_flash = rom.ok && (a <= rom.top);

    // Overlap is software's to avoid; expansion RAM wins if it happens
    wire logic overlap = rom.ok && xr.en && (xr.base <= rom.top);

    region_t region;
    always_comb begin
        if (in_sfr) region = RGN_SFR;
        else if (in_hs) region = RGN_HS_RAM;
        else if (in_exp) region = RGN_EXP_RAM;
        else if (in_win) region = bank_ok ? RGN_BANK : RGN_NONE;
        else if (in_flash) region = RGN_FLASH;
        else region = RGN_NONE;
    end

    // Window offset lands behind the common area, bank after bank
    wire logic [16:0] win_phys = `WIN_PHYS_BASE + 17'({bank, a[13:0]});
    wire logic [16:0] phys = (region == RGN_BANK) ? win_phys : {1'b0, a};

    wire logic [15:0] mirror = a - `SWAP_OFFSET;
    wire logic opt_main = in_range(a, `OPT_BASE, `OPT_TOP);
    wire logic opt_mir = boot_swap_i && in_range(mirror, `OPT_BASE, `OPT_TOP);
    wire logic dbg_main = in_range(a, `DBG_BASE, `DBG_TOP);
    wire logic dbg_mir = boot_swap_i && in_range(mirror, `DBG_BASE, `DBG_TOP);

    area_t area;
    assign area.vector = a <= `VEC_TOP;
    assign area.table_call = in_range(a, `TCALL_BASE, `TCALL_TOP);
    assign area.option_byte = opt_main || opt_mir;
    assign area.debug_id = HAS_DEBUG_ID && (dbg_main || dbg_mir);
    assign area.short_call = in_range(a, `SCALL_BASE, `SCALL_TOP);

    // Slot 0002H carries no vector; interrupts run 0004H to 0034H
    wire logic vec_slot = (a == `VEC_RESET) ||
                          in_range(a, `VEC_FIRST_IRQ, `VEC_LAST_IRQ);
    wire logic vec_ok = vec_slot && !a[0];
    wire logic tcall_ok = area.table_call && !a[0];

    logic illegal;
    always_comb begin
        unique case (req_i.kind)
            ACC_VECTOR: illegal = !vec_ok;
            ACC_TABLE_CALL: illegal = !tcall_ok;
            ACC_SHORT_CALL: illegal = !area.short_call;
            default: illegal = (region == RGN_NONE);
        endcase
    end

    wire logic blocked = (req_i.kind == ACC_WRITE) && boot0_protect_i &&
                         (a <= `BOOT0_TOP);

    // Vector entry high byte sits at the odd address
    wire logic entry_hi = a[0];

    acc_resp_t nxt_resp;
    assign nxt_resp = '{valid: req_i.valid, kind: req_i.kind, addr: a, region: region,
                        phys: phys, area: area, entry_hi: entry_hi,
                        illegal: illegal, blocked: blocked};

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            resp_o <= '0;
            cfg_error_o <= 1'b0;
        end else begin
            resp_o <= nxt_resp;
            cfg_error_o <= !rom.ok || !xr.ok || overlap;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    a_resp_follows: assert property (req_i.valid |=> resp_o.valid)
        else $error("request not answered next cycle");
    a_size_effect: assert property (mss_wr_i && wdata_i == `MSS_16K ##1 req_i.valid &&
                                    req_i.addr == 16'h4000 && !xr.en
                                    |=> resp_o.region == RGN_NONE)
        else $error("new flash size not applied to next access");
    a_flash_top: assert property (resp_o.valid && resp_o.region == RGN_FLASH
                                  |-> resp_o.addr <= $past(rom.top))
        else $error("flash decoded above its top");
    a_bank_phys: assert property (resp_o.valid && resp_o.region == RGN_BANK
                                  |-> resp_o.phys[16:14] == $past(bank) + 3'h2)
        else $error("window mapped to wrong bank");
    a_window_only: assert property (resp_o.region == RGN_BANK
                                    |-> resp_o.addr[15:14] == 2'b10)
        else $error("bank region outside window");
    a_reset_vector: assert property (req_i.valid && req_i.kind == ACC_VECTOR &&
                                     req_i.addr == `VEC_RESET |=> !resp_o.illegal)
        else $error("reset vector refused");
    a_vector_odd: assert property (resp_o.kind == ACC_VECTOR && resp_o.addr[0]
                                   |-> resp_o.illegal && resp_o.entry_hi)
        else $error("odd vector address accepted");
    a_short_call: assert property (resp_o.kind == ACC_SHORT_CALL && !resp_o.illegal
                                   |-> resp_o.addr[15:11] == 5'h01)
        else $error("short call outside entry area");
    a_boot_block: assert property (req_i.kind == ACC_WRITE && boot0_protect_i &&
                                   req_i.addr <= `BOOT0_TOP |=> resp_o.blocked)
        else $error("boot cluster write not blocked");
    a_opt_mirror: assert property (resp_o.area.option_byte && resp_o.addr[12]
                                   |-> $past(boot_swap_i))
        else $error("option mirror used without swap");
    // Registered answer against the address that asked for it
    a_vector_area: assert property (req_i.addr <= `VEC_TOP |=> resp_o.area.vector)
        else $error("vector area not flagged");
    a_table_area: assert property (req_i.addr >= `TCALL_BASE && req_i.addr <= `TCALL_TOP
                                   |=> resp_o.area.table_call)
        else $error("table call area not flagged");
    a_opt_main: assert property (req_i.addr >= `OPT_BASE && req_i.addr <= `OPT_TOP
                                 |=> resp_o.area.option_byte)
        else $error("option byte area not flagged");
    a_debug_main: assert property (HAS_DEBUG_ID && req_i.addr >= `DBG_BASE &&
                                   req_i.addr <= `DBG_TOP |=> resp_o.area.debug_id)
        else $error("debug identifier area not flagged");
    a_irq_slot: assert property (req_i.kind == ACC_VECTOR && req_i.addr == `VEC_LAST_IRQ
                                 |=> !resp_o.illegal)
        else $error("last interrupt slot refused");
    a_sfr_first: assert property (req_i.addr >= `SFR_BASE |=> resp_o.region == RGN_SFR)
        else $error("special register area not decoded");
    a_flat_phys: assert property (resp_o.region != RGN_BANK
                                  |-> resp_o.phys == {1'b0, resp_o.addr})
        else $error("unbanked access translated");
    a_exp_region: assert property (resp_o.region == RGN_EXP_RAM
                                   |-> resp_o.addr <= `XR_TOP && $past(xr.en))
        else $error("expansion RAM decoded while absent");
    a_hs_region: assert property (resp_o.region == RGN_HS_RAM
                                  |-> resp_o.addr >= $past(rom.hs_base) &&
                                  resp_o.addr <= `HS_TOP)
        else $error("fast RAM decoded outside its range");
    a_cfg_flag: assert property (!rom.ok |=> cfg_error_o)
        else $error("unknown size code not flagged");
    a_fetch_flash: assert property (req_i.kind == ACC_FETCH && rom.ok &&
                                    req_i.addr <= rom.top && req_i.addr < `WIN_BASE
                                    |=> !resp_o.illegal)
        else $error("fetch from flash refused");

endmodule : cpu_memory_map_decoder

`default_nettype wire

// >>> mem_map_params.svh
`ifndef MEM_MAP_PARAMS_SVH
`define MEM_MAP_PARAMS_SVH

// Size register reset values
`define MEM_SIZE_RST 8'hcf
`define EXP_RAM_RST 8'h0c

// Memory size select codes
`define MSS_16K 8'h04
`define MSS_24K 8'hc6
`define MSS_32K 8'hc8
`define MSS_48K 8'hcc
`define MSS_60K 8'hcf

// Expansion RAM size select codes
`define XSS_NONE 8'h0c
`define XSS_1K 8'h0a
`define XSS_2K 8'h08
`define XSS_4K 8'h04
`define XSS_6K 8'h00

// Flash tops per size
`define TOP_16K 16'h3fff
`define TOP_24K 16'h5fff
`define TOP_32K 16'h7fff
`define TOP_48K 16'hbfff
`define TOP_60K 16'hefff

// Expansion RAM bases, common top
`define XR_BASE_1K 16'hf400
`define XR_BASE_2K 16'hf000
`define XR_BASE_4K 16'he800
`define XR_BASE_6K 16'he000
`define XR_TOP 16'hf7ff

// High-speed RAM and special register area
`define HS_BASE_768 16'hfc00
`define HS_BASE_1K 16'hfb00
`define HS_TOP 16'hfeff
`define SFR_BASE 16'hff00

// Bank window
`define WIN_BASE 16'h8000
`define WIN_TOP 16'hbfff
`define WIN_PHYS_BASE 17'h08000

// Reserved low-memory areas
`define VEC_TOP 16'h003f
`define VEC_RESET 16'h0000
`define VEC_FIRST_IRQ 16'h0004
`define VEC_LAST_IRQ 16'h0034
`define TCALL_BASE 16'h0040
`define TCALL_TOP 16'h007f
`define OPT_BASE 16'h0080
`define OPT_TOP 16'h0084
`define DBG_BASE 16'h0085
`define DBG_TOP 16'h008e
`define SWAP_OFFSET 16'h1000
`define SCALL_BASE 16'h0800
`define SCALL_TOP 16'h0fff
`define BOOT0_TOP 16'h0fff

`endif

// >>> mem_map_pkg.sv
`default_nettype none
`include "mem_map_params.svh"

package mem_map_pkg;

    typedef enum logic [2:0] {
        ACC_FETCH,
        ACC_READ,
        ACC_WRITE,
        ACC_VECTOR,
        ACC_TABLE_CALL,
        ACC_SHORT_CALL
    } acc_kind_t;

    typedef enum logic [2:0] {
        RGN_NONE,
        RGN_FLASH,
        RGN_BANK,
        RGN_EXP_RAM,
        RGN_HS_RAM,
        RGN_SFR
    } region_t;

    typedef struct packed {
        logic valid;
        acc_kind_t kind;
        logic [15:0] addr;
    } acc_req_t;

    typedef struct packed {
        logic vector;
        logic table_call;
        logic option_byte;
        logic debug_id;
        logic short_call;
    } area_t;

    typedef struct packed {
        logic valid;
        acc_kind_t kind;
        logic [15:0] addr;
        region_t region;
        logic [16:0] phys;
        area_t area;
        logic entry_hi;
        logic illegal;
        logic blocked;
    } acc_resp_t;

    typedef struct packed {
        logic ok;
        logic [15:0] top;
        logic [15:0] hs_base;
    } rom_cfg_t;

    typedef struct packed {
        logic ok;
        logic en;
        logic [15:0] base;
    } exp_cfg_t;

    function automatic rom_cfg_t rom_decode(input logic [7:0] code);
        rom_cfg_t r;
        r = '{ok: 1'b1, top: `TOP_60K, hs_base: `HS_BASE_1K};
        case (code)
            `MSS_16K: begin
                r.top = `TOP_16K;
                r.hs_base = `HS_BASE_768;
            end
            `MSS_24K: r.top = `TOP_24K;
            `MSS_32K: r.top = `TOP_32K;
            `MSS_48K: r.top = `TOP_48K;
            `MSS_60K: r.top = `TOP_60K;
            default: r.ok = 1'b0;
        endcase
        return r;
    endfunction : rom_decode

    function automatic exp_cfg_t exp_decode(input logic [7:0] code);
        exp_cfg_t x;
        x = '{ok: 1'b1, en: 1'b1, base: `XR_BASE_6K};
        case (code)
            `XSS_NONE: x.en = 1'b0;
            `XSS_1K: x.base = `XR_BASE_1K;
            `XSS_2K: x.base = `XR_BASE_2K;
            `XSS_4K: x.base = `XR_BASE_4K;
            `XSS_6K: x.base = `XR_BASE_6K;
            default: begin
                x.ok = 1'b0;
                x.en = 1'b0;
            end
        endcase
        return x;
    endfunction : exp_decode

    function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                      input logic [15:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction : in_range

endpackage : mem_map_pkg

`default_nettype wire

// >>> mem_map_size_regs.sv
`default_nettype none
`include "mem_map_params.svh"

module mem_map_size_regs
    import mem_map_pkg::*;
#(
    parameter int BANK_W = 3
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Register writes from the core, same clock
    input wire logic mss_wr_i,
    input wire logic xss_wr_i,
    input wire logic bank_wr_i,
    input wire logic [7:0] wdata_i,
    // Held values
    output logic [7:0] mss_o,
    output logic [7:0] xss_o,
    output logic [BANK_W-1:0] bank_o
);

    // Reset values fixed whatever memory is fitted
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mss_o <= `MEM_SIZE_RST;
            xss_o <= `EXP_RAM_RST;
            bank_o <= '0;
        end else begin
            if (mss_wr_i) mss_o <= wdata_i;
            if (xss_wr_i) xss_o <= wdata_i;
            if (bank_wr_i) bank_o <= wdata_i[BANK_W-1:0];
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    a_mss_write: assert property (mss_wr_i |=> mss_o == $past(wdata_i))
        else $error("size select not loaded");
    a_xss_hold: assert property (!xss_wr_i |=> $stable(xss_o))
        else $error("expansion size changed without write");
    a_bank_write: assert property (bank_wr_i ##1 !bank_wr_i[*2]
                                   |-> bank_o == $past(wdata_i[BANK_W-1:0], 2))
        else $error("bank select not held");

endmodule : mem_map_size_regs

`default_nettype wire

// >>> testbench.sv
`default_nettype none
module testbench
    import mem_map_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NB = 6;
    localparam logic [15:0] CFG [7] = '{16'h040c, 16'hc60c, 16'hc80c, 16'hcc0a,
        16'hcf08, 16'hcc04, 16'hcc00};
    localparam logic [15:0] CORN [34] = '{16'h0000, 16'h0001, 16'h0004, 16'h0034,
        16'h0036, 16'h003f, 16'h0040, 16'h007f, 16'h0080, 16'h0084, 16'h0085, 16'h008e,
        16'h0800, 16'h0fff, 16'h1000, 16'h1084, 16'h108e, 16'h3fff, 16'h4000, 16'h5fff,
        16'h6000, 16'h7fff, 16'h8000, 16'hbfff, 16'hc000, 16'hefff, 16'hf000, 16'he800,
        16'hf3ff, 16'hf7ff, 16'hf800, 16'hfb00, 16'hfc00, 16'hff00};
    logic clk_i, resetn_i, mss_wr_i, xss_wr_i, bank_wr_i, boot_swap_i, boot0_protect_i;
    logic [7:0] wdata_i, mss_o, xss_o, cur_mss, cur_xss;
    logic [2:0] bank_o, bk;
    logic cfg_err;
    acc_req_t req;
    acc_resp_t resp;
    int fails, tests_run, cyc, seed;

    cpu_core_model core_u (.clk_i(clk_i), .req_o(req));

    cpu_memory_map_decoder #(.NUM_BANKS(NB), .HAS_DEBUG_ID(1'b1)) dut_u (
        .clk_i(clk_i), .resetn_i(resetn_i), .mss_wr_i(mss_wr_i), .xss_wr_i(xss_wr_i),
        .bank_wr_i(bank_wr_i), .wdata_i(wdata_i), .boot_swap_i(boot_swap_i),
        .boot0_protect_i(boot0_protect_i), .req_i(req), .resp_o(resp),
        .memory_size_select_o(mss_o), .expansion_ram_size_select_o(xss_o),
        .bank_sel_o(bank_o), .cfg_error_o(cfg_err));

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    task automatic summarize();
        $display("Counts: run=%0d mismatches=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize

    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            summarize();
        end
    end

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input int sel, input logic [7:0] d);
        @(posedge clk_i);
        #1 wdata_i = d;
        {bank_wr_i, xss_wr_i, mss_wr_i} = 3'b001 << sel;
        @(posedge clk_i);
        #1 {bank_wr_i, xss_wr_i, mss_wr_i} = 3'b000;
    endtask : wr

    function automatic logic in_win(logic [15:0] a, logic [15:0] lo, logic [15:0] hi);
        return a >= lo && a <= hi;
    endfunction : in_win

    function automatic acc_resp_t expect_resp(acc_kind_t k, logic [15:0] a);
        acc_resp_t e;
        logic [15:0] top, hs, xb;
        top = cur_mss == 8'h04 ? 16'h3fff : cur_mss == 8'hc6 ? 16'h5fff :
            cur_mss == 8'hc8 ? 16'h7fff : cur_mss == 8'hcc ? 16'hbfff : 16'hefff;
        hs = cur_mss == 8'h04 ? 16'hfc00 : 16'hfb00;
        xb = cur_xss == 8'h0a ? 16'hf400 : cur_xss == 8'h08 ? 16'hf000 :
            cur_xss == 8'h04 ? 16'he800 : 16'he000;
        e = '0;
        e.valid = 1'b1;
        e.kind = k;
        e.addr = a;
        e.phys = {1'b0, a};
        e.entry_hi = a[0];
        if (a >= 16'hff00) e.region = RGN_SFR;
        else if (in_win(a, hs, 16'hfeff)) e.region = RGN_HS_RAM;
        else if (cur_xss != 8'h0c && in_win(a, xb, 16'hf7ff)) e.region = RGN_EXP_RAM;
        else if (cur_mss == 8'hcc && in_win(a, 16'h8000, 16'hbfff)) begin
            e.region = RGN_BANK;
            e.phys = 17'h08000 + 17'(bk) * 17'h04000 + 17'(a[13:0]);
        end else if (a <= top) e.region = RGN_FLASH;
        e.area.vector = a <= 16'h003f;
        e.area.table_call = in_win(a, 16'h0040, 16'h007f);
        e.area.option_byte = in_win(a, 16'h0080, 16'h0084) ||
            (boot_swap_i && in_win(a, 16'h1080, 16'h1084));
        e.area.debug_id = in_win(a, 16'h0085, 16'h008e) ||
            (boot_swap_i && in_win(a, 16'h1085, 16'h108e));
        e.area.short_call = in_win(a, 16'h0800, 16'h0fff);
        case (k)
            ACC_VECTOR: e.illegal = a[0] || !(a == 16'h0 || in_win(a, 16'h4, 16'h34));
            ACC_TABLE_CALL: e.illegal = a[0] || !in_win(a, 16'h40, 16'h7f);
            ACC_SHORT_CALL: e.illegal = !in_win(a, 16'h0800, 16'h0fff);
            default: e.illegal = e.region == RGN_NONE;
        endcase
        e.blocked = boot0_protect_i && k == ACC_WRITE && a <= 16'h0fff;
        return e;
    endfunction : expect_resp

    task automatic acc(input acc_kind_t k, input logic [15:0] a);
        acc_resp_t e;
        boot_swap_i = 1'($random(seed));
        boot0_protect_i = 1'($random(seed));
        e = expect_resp(k, a);
        core_u.issue(k, a);
        chk(64'(resp), 64'(e));
    endtask : acc

    initial begin
        seed = 32'hf14f;
        {resetn_i, mss_wr_i, xss_wr_i, bank_wr_i, boot_swap_i, boot0_protect_i} = '0;
        wdata_i = 8'h00;
        repeat (12) @(posedge clk_i);
        #1 resetn_i = 1'b1;
        chk(64'(mss_o), 64'h00cf);
        chk(64'(xss_o), 64'h000c);
        chk(64'(cfg_err), 64'h0);
        // Access right behind a size write must already see the new size
        cur_mss = 8'h04;
        cur_xss = 8'h0c;
        fork
            wr(0, 8'h04);
            begin
                @(posedge clk_i);
                core_u.issue(ACC_READ, 16'h4000);
            end
        join
        chk(64'(resp), 64'(expect_resp(ACC_READ, 16'h4000)));
        $display("Test size switch done");
        for (int c = 0; c < 7; c++) begin
            cur_mss = CFG[c][15:8];
            cur_xss = CFG[c][7:0];
            bk = 3'($unsigned($random(seed)) % NB);
            wr(0, cur_mss);
            wr(1, cur_xss);
            wr(2, {5'h00, bk});
            @(posedge clk_i);
            #1 chk(64'(mss_o), 64'(cur_mss));
            chk(64'(xss_o), 64'(cur_xss));
            chk(64'(bank_o), 64'(bk));
            chk(64'(cfg_err), 64'h0);
            foreach (CORN[i]) for (int k = 0; k < 6; k++) acc(acc_kind_t'(k), CORN[i]);
            repeat (40) acc(acc_kind_t'($unsigned($random(seed)) % 6), 16'($random(seed)));
            $display("Test config %0d done", c);
        end
        // Unknown size code, then overlapping sizes, both flagged
        wr(0, 8'h55);
        @(posedge clk_i);
        #1 chk(64'(cfg_err), 64'h1);
        wr(0, 8'hcf);
        wr(1, 8'h00);
        @(posedge clk_i);
        #1 chk(64'(cfg_err), 64'h1);
        $display("Test config errors done");
        summarize();
    end
endmodule : testbench
`default_nettype wire
